// ==== hdl/dma_cfg_pkg.sv ====
// package for the data configuration / dma block: register map, field layouts,
// reset values, fifo sizes and the threshold and lane decoders.
// assumes one 8-bit register port and one system clock.
package dma_cfg_pkg;

  localparam logic [3:0] OFS_COMMAND = 4'h0;
  localparam logic [3:0] OFS_LOCAL_START_LO = 4'h1;
  localparam logic [3:0] OFS_LOCAL_START_HI = 4'h2;
  localparam logic [3:0] OFS_REMOTE_START_LO = 4'h8;
  localparam logic [3:0] OFS_REMOTE_START_HI = 4'h9;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  localparam logic [3:0] OFS_TRANSMIT_CONFIG = 4'hd;
  localparam logic [3:0] OFS_DATA_CONFIG = 4'he;

  localparam int CMD_FETCH_BIT = 0;
  localparam int TCR_LOOP_LSB = 1;

  typedef struct packed {
    logic reserved;
    logic fifo_level_code_hi;
    logic fifo_level_code_lo;
    logic auto_packet_removal;
    logic loopback_sel;
    logic long_addressing_sel;
    logic byte_lane_order;
    logic word_transfer_sel;
  } data_configuration_t;

  localparam logic [7:0] DCR_RESET = 8'h04;
  localparam logic [1:0] TCR_LOOP_RESET = 2'h0;

  localparam int FIFO_AW = 4;
  localparam logic [4:0] FIFO_BYTES = 5'h10;
  localparam logic [4:0] THR_CODE0_BYTES = 5'h02;
  localparam logic [15:0] ADDR_STEP_BYTE = 16'h0001;
  localparam logic [14:0] ADDR_STEP_WORD = 15'h0001;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
    logic word;
  } mem_wr_t;

  typedef struct packed {
    logic [4:0] level;
    logic busy;
    logic loopback;
    logic fetch_refused;
  } status_t;

  function automatic logic [4:0] thr_bytes(input logic [1:0] code);
    return (code == 2'h0) ? THR_CODE0_BYTES : 5'({code, 2'h0});
  endfunction

  function automatic logic [3:0] burst_xfers(input logic [1:0] code, input logic word);
    logic [4:0] b;
    b = thr_bytes(code);
    return word ? b[4:1] : b[3:0];
  endfunction

  function automatic logic [15:0] lanes(input logic [15:0] w, input logic order,
                                        input logic word);
    return (word && order) ? {w[7:0], w[15:8]} : w;
  endfunction

endpackage

// ==== hdl/fifo_byte_mem.sv ====
// 16 x 8 byte store for the network fifo.
// one write port, one read port whose data come from a register and hold
// until the next read.
`timescale 1ns/10ps
module fifo_byte_mem (
  input wire logic core_clk, // system clock
  input wire logic we, // write enable
  input wire logic [dma_cfg_pkg::FIFO_AW-1:0] waddr, // write address
  input wire logic [7:0] wdata, // write byte
  input wire logic re, // read enable
  input wire logic [dma_cfg_pkg::FIFO_AW-1:0] raddr, // read address
  output logic [7:0] rdata // read byte, valid the cycle after re
);
  logic [7:0] mem [2**dma_cfg_pkg::FIFO_AW];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule

// ==== hdl/two_slot_buffer.sv ====
// two-entry buffer with valid/ready on both sides; outputs are the head
// registers, so a stall on the out side never drops a word.
`timescale 1ns/10ps
module two_slot_buffer #(
  parameter type T = dma_cfg_pkg::mem_wr_t
) (
  input wire logic core_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic in_valid, // word offered
  input T in_data, // offered word
  output logic in_ready, // room for a word
  output logic out_valid, // head holds a word
  output T out_data, // head word
  input wire logic out_ready // sink takes head
);
  T tail_reg;
  logic tail_valid_reg;
  logic push;
  logic pop;

  assign in_ready = !tail_valid_reg;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      tail_valid_reg <= 1'b0;
    end else if (pop) begin
      out_valid <= tail_valid_reg || push;
      tail_valid_reg <= tail_valid_reg && push;
    end else if (push) begin
      out_valid <= 1'b1;
      tail_valid_reg <= out_valid;
    end
  end

  always_ff @(posedge core_clk) begin
    if (pop) begin
      out_data <= tail_valid_reg ? tail_reg : in_data;
      tail_reg <= in_data;
    end else if (push) begin
      if (out_valid) begin
        tail_reg <= in_data;
      end else begin
        out_data <= in_data;
      end
    end
  end
endmodule

// ==== hdl/dma_data_config.sv ====
// data configuration and burst dma for the network fifo.
// assumes one system clock, a host register port with read data one cycle
// later, and a memory bus that grants the bus after a request.
// Operation
// - word bit picks byte or word transfers
// - word mode keeps lowest address line low
// - lane-order bit swaps upper and lower byte lanes
// - lane order ignored for byte transfers
// - long addressing bit, set at power-up
// - long mode drives remote start on upper lines
// - loopback needs select clear and nonzero code
// - auto removal bit gates the packet fetch
// - receive request waits for threshold fifo fill
// - threshold code gives 2, 4, 8, 12 bytes
// - transmit threshold is sixteen minus receive threshold
// - burst length follows the threshold code
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
module dma_data_config (
  input wire logic core_clk, // 200 MHz system clock
  input wire logic nrst, // async reset, active low
  input wire logic [3:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after reg_rd
  input wire logic tx_active, // 1: transmit direction, 0: receive
  input wire logic net_rx_valid, // byte from network
  input wire logic [7:0] net_rx_data, // received byte
  output logic net_tx_valid, // byte to network valid
  output logic [7:0] net_tx_data, // byte to network
  input wire logic net_tx_ready, // network takes byte
  output logic bus_request_out, // memory bus request
  input wire logic bus_grant, // memory bus granted
  output logic mem_wr_valid, // write transfer valid
  output dma_cfg_pkg::mem_wr_t mem_wr, // write address, data, width
  input wire logic mem_wr_ready, // memory takes write
  output logic [15:0] mem_rd_addr, // read address during transmit
  output logic mem_rd_ready, // ready for read data
  input wire logic mem_rd_valid, // read data valid
  input wire logic [15:0] mem_rd_data, // read data on both lanes
  output logic [15:0] upper_address_lines, // upper address in long mode
  input wire logic [15:0] ring_next_packet, // next packet pointer of the ring
  output logic remote_fetch_start, // one-cycle pulse: remote dma started
  output logic loopback_en // loopback in force
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_REQ = 3'b001,
    S_FETCH_LO = 3'b011,
    S_FETCH_HI = 3'b010,
    S_PUSH = 3'b110,
    S_TX_WAIT = 3'b111,
    S_TX_LO = 3'b101,
    S_TX_HI = 3'b100
  } state_t;

  dma_cfg_pkg::data_configuration_t dcr_reg;
  dma_cfg_pkg::data_configuration_t cfg_act_reg;
  state_t state_reg;
  state_t state_next;
  logic [1:0] tcr_loop_reg;
  logic [15:0] local_start_reg;
  logic [15:0] remote_start_reg;
  logic [15:0] local_addr_reg;
  logic [3:0] burst_left_reg;
  logic [7:0] lo_byte_reg;
  logic [15:0] tx_word_reg;
  logic [3:0] wr_ptr_reg;
  logic [3:0] rd_ptr_reg;
  logic [4:0] level_reg;
  logic fetch_refused_reg;
  logic [1:0] code;
  logic [1:0] act_code;
  logic rx_go;
  logic tx_go;
  logic owning;
  logic fifo_we;
  logic fifo_re;
  logic [7:0] fifo_wdata;
  logic [7:0] fifo_rdata;
  logic net_rd;
  logic buf_in_valid;
  logic buf_in_ready;
  dma_cfg_pkg::mem_wr_t buf_in;
  logic [15:0] canon;
  logic [15:0] addr_out;
  logic step;
  logic wr_hit;
  logic [7:0] reg_next;

  assign code = {dcr_reg.fifo_level_code_hi, dcr_reg.fifo_level_code_lo};
  assign act_code = {cfg_act_reg.fifo_level_code_hi, cfg_act_reg.fifo_level_code_lo};
  assign rx_go = !tx_active && level_reg >= dma_cfg_pkg::thr_bytes(code);
  assign tx_go = tx_active &&
    level_reg <= dma_cfg_pkg::FIFO_BYTES - dma_cfg_pkg::thr_bytes(code);
  assign owning = state_reg != S_IDLE && state_reg != S_REQ;
  assign wr_hit = reg_wr && reg_addr == dma_cfg_pkg::OFS_COMMAND &&
    reg_wdata[dma_cfg_pkg::CMD_FETCH_BIT];

  // burst sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE: begin
        if (rx_go || tx_go) begin
          state_next = S_REQ;
        end
      end
      S_REQ: begin
        if (bus_grant) begin
          state_next = tx_active ? S_TX_WAIT : S_FETCH_LO;
        end
      end
      S_FETCH_LO: begin
        state_next = cfg_act_reg.word_transfer_sel ? S_FETCH_HI : S_PUSH;
      end
      S_FETCH_HI: state_next = S_PUSH;
      S_PUSH: begin
        if (buf_in_ready) begin
          state_next = (burst_left_reg == 4'h1) ? S_IDLE : S_FETCH_LO;
        end
      end
      S_TX_WAIT: begin
        if (mem_rd_valid) begin
          state_next = S_TX_LO;
        end
      end
      S_TX_LO: begin
        if (cfg_act_reg.word_transfer_sel) begin
          state_next = S_TX_HI;
        end else begin
          state_next = (burst_left_reg == 4'h1) ? S_IDLE : S_TX_WAIT;
        end
      end
      S_TX_HI: state_next = (burst_left_reg == 4'h1) ? S_IDLE : S_TX_WAIT;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // configuration is latched only as a burst opens
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_act_reg <= dma_cfg_pkg::DCR_RESET;
      burst_left_reg <= 4'h0;
    end else begin
      if (state_reg == S_IDLE && state_next == S_REQ) begin
        cfg_act_reg <= dcr_reg;
        burst_left_reg <= dma_cfg_pkg::burst_xfers(code, dcr_reg.word_transfer_sel);
      end else if ((state_reg == S_PUSH && buf_in_ready) ||
                   (state_reg == S_TX_LO && !cfg_act_reg.word_transfer_sel) ||
                   state_reg == S_TX_HI) begin
        burst_left_reg <= burst_left_reg - 4'h1;
      end
    end
  end

  // host registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dcr_reg <= dma_cfg_pkg::DCR_RESET;
      tcr_loop_reg <= dma_cfg_pkg::TCR_LOOP_RESET;
      local_start_reg <= 16'h0000;
    end else if (reg_wr) begin
      if (reg_addr == dma_cfg_pkg::OFS_DATA_CONFIG) begin
        dcr_reg <= reg_wdata;
      end
      if (reg_addr == dma_cfg_pkg::OFS_TRANSMIT_CONFIG) begin
        tcr_loop_reg <= reg_wdata[dma_cfg_pkg::TCR_LOOP_LSB +: 2];
      end
      if (reg_addr == dma_cfg_pkg::OFS_LOCAL_START_LO) begin
        local_start_reg[7:0] <= reg_wdata;
      end
      if (reg_addr == dma_cfg_pkg::OFS_LOCAL_START_HI) begin
        local_start_reg[15:8] <= reg_wdata;
      end
    end
  end

  // packet fetch runs only with auto removal set
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      remote_start_reg <= 16'h0000;
      remote_fetch_start <= 1'b0;
      fetch_refused_reg <= 1'b0;
    end else begin
      remote_fetch_start <= wr_hit && dcr_reg.auto_packet_removal;
      if (wr_hit && dcr_reg.auto_packet_removal) begin
        remote_start_reg <= ring_next_packet;
      end else if (reg_wr && reg_addr == dma_cfg_pkg::OFS_REMOTE_START_LO) begin
        remote_start_reg[7:0] <= reg_wdata;
      end else if (reg_wr && reg_addr == dma_cfg_pkg::OFS_REMOTE_START_HI) begin
        remote_start_reg[15:8] <= reg_wdata;
      end
      // refusal set wins over the clear-on-read
      if (wr_hit && !dcr_reg.auto_packet_removal) begin
        fetch_refused_reg <= 1'b1;
      end else if (reg_rd && reg_addr == dma_cfg_pkg::OFS_STATUS) begin
        fetch_refused_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    reg_next = 8'h00;
    if (reg_addr == dma_cfg_pkg::OFS_STATUS) begin
      reg_next = dma_cfg_pkg::status_t'({level_reg, state_reg != S_IDLE, loopback_en,
                                          fetch_refused_reg});
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? reg_next : 8'h00;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      loopback_en <= 1'b0;
    end else begin
      loopback_en <= !dcr_reg.loopback_sel && tcr_loop_reg != 2'h0;
    end
  end

  // local address: word steps keep bit 0 low, so 32k words are reachable
  assign addr_out = {local_addr_reg[15:1],
                     local_addr_reg[0] && !cfg_act_reg.word_transfer_sel};
  assign step = (state_reg == S_PUSH && buf_in_ready) ||
    (state_reg == S_TX_WAIT && mem_rd_valid);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      local_addr_reg <= 16'h0000;
    end else if (reg_wr && (reg_addr == dma_cfg_pkg::OFS_LOCAL_START_LO ||
                            reg_addr == dma_cfg_pkg::OFS_LOCAL_START_HI)) begin
      local_addr_reg <= (reg_addr == dma_cfg_pkg::OFS_LOCAL_START_LO) ?
        {local_start_reg[15:8], reg_wdata} : {reg_wdata, local_start_reg[7:0]};
    end else if (step) begin
      if (cfg_act_reg.word_transfer_sel) begin
        local_addr_reg <= {local_addr_reg[15:1] + dma_cfg_pkg::ADDR_STEP_WORD, 1'b0};
      end else begin
        local_addr_reg <= local_addr_reg + dma_cfg_pkg::ADDR_STEP_BYTE;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus_request_out <= 1'b0;
      upper_address_lines <= 16'h0000;
      mem_rd_ready <= 1'b0;
      mem_rd_addr <= 16'h0000;
    end else begin
      bus_request_out <= state_next != S_IDLE;
      upper_address_lines <= (owning && cfg_act_reg.long_addressing_sel) ?
        remote_start_reg : 16'h0000;
      mem_rd_ready <= state_next == S_TX_WAIT;
      mem_rd_addr <= addr_out;
    end
  end

  // fifo: network fills and dma drains on receive, the reverse on transmit
  assign net_rd = tx_active && level_reg != 5'h00 && (!net_tx_valid || net_tx_ready) &&
    state_reg != S_TX_LO && state_reg != S_TX_HI;
  assign fifo_re = tx_active ? net_rd : (state_reg == S_FETCH_LO || state_reg == S_FETCH_HI);
  assign canon = dma_cfg_pkg::lanes(tx_word_reg, cfg_act_reg.byte_lane_order,
                                    cfg_act_reg.word_transfer_sel);
  assign fifo_we = tx_active ? (state_reg == S_TX_LO || state_reg == S_TX_HI) :
    (net_rx_valid && level_reg != dma_cfg_pkg::FIFO_BYTES);
  assign fifo_wdata = !tx_active ? net_rx_data :
    (state_reg == S_TX_HI ? canon[15:8] : canon[7:0]);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      level_reg <= 5'h00;
      net_tx_valid <= 1'b0;
    end else begin
      if (fifo_we) begin
        wr_ptr_reg <= wr_ptr_reg + 4'h1;
      end
      if (fifo_re) begin
        rd_ptr_reg <= rd_ptr_reg + 4'h1;
      end
      level_reg <= level_reg + {4'h0, fifo_we} - {4'h0, fifo_re};
      net_tx_valid <= net_rd || (net_tx_valid && !net_tx_ready);
    end
  end

  assign net_tx_data = fifo_rdata;

  always_ff @(posedge core_clk) begin
    if (state_reg == S_FETCH_HI) begin
      lo_byte_reg <= fifo_rdata;
    end
    if (state_reg == S_TX_WAIT && mem_rd_valid) begin
      tx_word_reg <= mem_rd_data;
    end
  end

  fifo_byte_mem u_mem (
    .core_clk(core_clk),
    .we(fifo_we),
    .waddr(wr_ptr_reg),
    .wdata(fifo_wdata),
    .re(fifo_re),
    .raddr(rd_ptr_reg),
    .rdata(fifo_rdata)
  );

  // first network byte is the less significant one while lane order is clear
  assign buf_in_valid = state_reg == S_PUSH;
  assign buf_in.addr = addr_out;
  assign buf_in.word = cfg_act_reg.word_transfer_sel;
  assign buf_in.data = cfg_act_reg.word_transfer_sel ?
    dma_cfg_pkg::lanes({fifo_rdata, lo_byte_reg}, cfg_act_reg.byte_lane_order, 1'b1) :
    {8'h00, fifo_rdata};

  two_slot_buffer #(.T(dma_cfg_pkg::mem_wr_t)) u_buf (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_valid(buf_in_valid),
    .in_data(buf_in),
    .in_ready(buf_in_ready),
    .out_valid(mem_wr_valid),
    .out_data(mem_wr),
    .out_ready(mem_wr_ready)
  );

  a_word_lsb_low: assert property (@(posedge core_clk) disable iff (!nrst)
    mem_wr_valid && mem_wr.word |-> !mem_wr.addr[0])
    else $error("word write with odd address");
  a_width_path: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg == S_FETCH_LO |=> state_reg == (cfg_act_reg.word_transfer_sel ? S_FETCH_HI : S_PUSH))
    else $error("transfer width not followed");
  a_lane_swap: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg == S_PUSH && cfg_act_reg.word_transfer_sel |->
      buf_in.data == (cfg_act_reg.byte_lane_order ? {lo_byte_reg, fifo_rdata}
                                                  : {fifo_rdata, lo_byte_reg}))
    else $error("byte lane order wrong");
  a_byte_no_swap: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg == S_PUSH && !cfg_act_reg.word_transfer_sel |-> buf_in.data[15:8] == 8'h00)
    else $error("byte transfer used upper lanes");
  a_upper_lines: assert property (@(posedge core_clk) disable iff (!nrst)
    owning && cfg_act_reg.long_addressing_sel |=> upper_address_lines == $past(remote_start_reg))
    else $error("upper address lines wrong");
  a_loopback_state: assert property (@(posedge core_clk) disable iff (!nrst)
    ##1 loopback_en == $past(!dcr_reg.loopback_sel && tcr_loop_reg != 2'h0))
    else $error("loopback output wrong");
  a_fetch_gate: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_hit |=> remote_fetch_start == $past(dcr_reg.auto_packet_removal) &&
      fetch_refused_reg == (!$past(dcr_reg.auto_packet_removal) ||
        $past(fetch_refused_reg && !(reg_rd && reg_addr == dma_cfg_pkg::OFS_STATUS))))
    else $error("packet fetch gating wrong");
  a_rx_request: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(bus_request_out) && !$past(tx_active) |->
      $past(level_reg) >= dma_cfg_pkg::thr_bytes($past(code)))
    else $error("receive request below threshold");
  a_tx_request: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(bus_request_out) && $past(tx_active) |->
      $past(level_reg) <= dma_cfg_pkg::FIFO_BYTES - dma_cfg_pkg::thr_bytes($past(code)))
    else $error("transmit request above threshold");
  a_burst_len: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg == S_IDLE && state_next == S_REQ |=>
      burst_left_reg == dma_cfg_pkg::burst_xfers(act_code, cfg_act_reg.word_transfer_sel))
    else $error("burst length wrong");
  a_cfg_stable: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg != S_IDLE && $past(state_reg) != S_IDLE |-> $stable(cfg_act_reg))
    else $error("configuration changed inside burst");
endmodule

// ==== testbench/mem_partner.sv ====
// memory bus partner: grants one cycle after a request, takes writes, answers reads.
// assumes the dma block's memory port; taken writes are logged in got.
`timescale 1ns/10ps
module mem_partner (
  input wire logic core_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic slow, // 1: drop write ready every other cycle
  input wire logic bus_request_out, // request from dma
  output logic bus_grant, // grant to dma
  input wire logic mem_wr_valid, // write offered
  input dma_cfg_pkg::mem_wr_t mem_wr, // write word
  output logic mem_wr_ready, // write taken
  input wire logic [15:0] mem_rd_addr, // read address
  input wire logic mem_rd_ready, // dma wants data
  output logic mem_rd_valid, // read data valid
  output logic [15:0] mem_rd_data // read data
);
  dma_cfg_pkg::mem_wr_t got[$];
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus_grant <= 1'b0;
      mem_wr_ready <= 1'b0;
      mem_rd_valid <= 1'b0;
      mem_rd_data <= 16'h0000;
    end else begin
      bus_grant <= bus_request_out;
      mem_wr_ready <= slow ? ~mem_wr_ready : 1'b1;
      mem_rd_valid <= mem_rd_ready && !mem_rd_valid;
      // lines wander outside a beat so stale data never passes for fresh
      mem_rd_data <= mem_rd_ready ? {mem_rd_addr[7:0], ~mem_rd_addr[7:0]} : ~mem_rd_data;
    end
  end
  always @(posedge core_clk) begin
    if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) begin
      got.push_back(mem_wr);
    end
  end
endmodule

// ==== testbench/dma_data_config_tb.sv ====
// self-checking bench for dma_data_config: register tasks, network byte feed.
// assumes the design package and mem_partner on the memory side.
`timescale 1ns/10ps
module dma_data_config_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic net_rx_valid = 1'b0;
  logic [7:0] net_rx_data = 8'h00;
  logic slow = 1'b0;
  logic tx_active = 1'b0;
  logic [15:0] ring_next_packet = 16'h0000;
  logic [7:0] reg_rdata, rv;
  logic bus_request_out, bus_grant, mem_wr_valid, mem_wr_ready, mem_rd_ready, mem_rd_valid;
  logic remote_fetch_start, loopback_en, net_tx_valid;
  logic [7:0] net_tx_data;
  logic [15:0] mem_rd_addr, mem_rd_data, upper_address_lines, exp_addr;
  logic [15:0] seen_upper = 16'h0000;
  dma_cfg_pkg::mem_wr_t mem_wr;
  int num_errors = 0;
  int tests_run = 0;
  int fetch_pulses = 0;

  dma_data_config uut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_active(tx_active), .net_rx_valid(net_rx_valid), .net_rx_data(net_rx_data),
    .net_tx_valid(net_tx_valid), .net_tx_data(net_tx_data), .net_tx_ready(1'b0),
    .bus_request_out(bus_request_out),
    .bus_grant(bus_grant), .mem_wr_valid(mem_wr_valid), .mem_wr(mem_wr),
    .mem_wr_ready(mem_wr_ready), .mem_rd_addr(mem_rd_addr), .mem_rd_ready(mem_rd_ready),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
    .upper_address_lines(upper_address_lines), .ring_next_packet(ring_next_packet),
    .remote_fetch_start(remote_fetch_start), .loopback_en(loopback_en));
  mem_partner mp (.core_clk(core_clk), .nrst(nrst), .slow(slow),
    .bus_request_out(bus_request_out), .bus_grant(bus_grant), .mem_wr_valid(mem_wr_valid),
    .mem_wr(mem_wr), .mem_wr_ready(mem_wr_ready), .mem_rd_addr(mem_rd_addr),
    .mem_rd_ready(mem_rd_ready), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  // pulses and upper lines are sampled in the background so no cycle is missed
  always @(posedge core_clk) begin
    if (remote_fetch_start === 1'b1) begin
      fetch_pulses++;
    end
    if (bus_grant === 1'b1 && bus_request_out === 1'b1) begin
      seen_upper <= upper_address_lines;
    end
  end
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic rx(input logic [7:0] b);
    @(posedge core_clk);
    net_rx_valid <= 1'b1;
    net_rx_data <= b;
    @(posedge core_clk);
    net_rx_valid <= 1'b0;
    #1;
  endtask
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic rx_burst(input int nb, input logic word, input logic order);
    int i;
    logic [7:0] lo, hi;
    mp.got.delete();
    for (i = 0; i < nb; i++) begin
      if (i == nb - 1) begin
        chk(16'(bus_request_out), 16'h0000);
      end
      rx(8'ha0 + 8'(i));
    end
    for (i = 0; i < 400 && mp.got.size() < (word ? nb / 2 : nb); i++) begin
      @(posedge core_clk);
    end
    chk(16'(mp.got.size()), 16'(word ? nb / 2 : nb));
    for (i = 0; i < mp.got.size(); i++) begin
      lo = 8'ha0 + 8'(word ? 2 * i : i);
      hi = word ? lo + 8'h01 : 8'h00;
      chk(mp.got[i].addr, exp_addr);
      chk(mp.got[i].data, (order & word) ? {lo, hi} : {hi, lo});
      chk(16'(mp.got[i].word), 16'(word));
      exp_addr = exp_addr + (word ? 16'h0002 : 16'h0001);
    end
  endtask

  initial begin
    int c;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    settle();
    chk(upper_address_lines, 16'h0000);
    rd(4'hc);
    chk(16'(rv), 16'h0000);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h01);
    wr(4'h8, 8'h34);
    wr(4'h9, 8'h12);
    exp_addr = 16'h0100;
    rx_burst(2, 1'b0, 1'b0);
    chk(seen_upper, 16'h1234);
    $display("test reset_long done");
    // lane order set on purpose: byte mode must ignore it
    for (c = 1; c < 4; c++) begin
      wr(4'he, {1'b0, 2'(c), 5'b01010});
      rx_burst(4 * c, 1'b0, 1'b1);
    end
    chk(seen_upper, 16'h0000);
    $display("test byte_thresholds done");
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h02);
    exp_addr = 16'h0200;
    for (c = 0; c < 2; c++) begin
      slow <= 1'(c);
      wr(4'he, {6'b001010, 1'(c), 1'b1});
      rx_burst(4, 1'b1, 1'(c));
    end
    slow <= 1'b0;
    $display("test word_lanes done");
    wr(4'he, 8'h08);
    wr(4'h0, 8'h01);
    rd(4'hc);
    chk(16'(rv[0]), 16'h0001);
    rd(4'hc);
    chk(16'(rv[0]), 16'h0000);
    chk(16'(fetch_pulses), 16'h0000);
    ring_next_packet <= 16'h4a5c;
    wr(4'he, 8'h18);
    wr(4'h0, 8'h01);
    settle();
    chk(16'(fetch_pulses), 16'h0001);
    $display("test packet_fetch done");
    wr(4'hd, 8'h04);
    settle();
    chk(16'(loopback_en), 16'h0000);
    wr(4'he, 8'h10);
    settle();
    chk(16'(loopback_en), 16'h0001);
    wr(4'hd, 8'h00);
    settle();
    chk(16'(loopback_en), 16'h0000);
    $display("test loopback done");
    // network side stalled: one byte parks on the output, the rest stay in the fifo
    wr(4'he, 8'h6c);
    tx_active <= 1'b1;
    repeat (80) @(posedge core_clk);
    #1;
    chk(seen_upper, 16'h4a5c);
    chk(16'(bus_request_out), 16'h0000);
    chk({7'h00, net_tx_valid, net_tx_data}, 16'h01f7);
    rd(4'hc);
    chk(16'(rv), 16'h0058);
    $display("test transmit done");
    finish_test();
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
endmodule
